// file: hdl/reset_source_sequencer_regs.vh
`ifndef RESET_SOURCE_SEQUENCER_REGS_VH
`define RESET_SOURCE_SEQUENCER_REGS_VH

// Register byte addresses
`define ADDR_CAUSE_FLAGS 12'h000
`define ADDR_PROC_MODE0 12'h004
`define ADDR_PROC_MODE1 12'h008
`define ADDR_OSC_CTRL2 12'h00C
`define ADDR_LVL_CTRL 12'h010
`define ADDR_STATUS 12'h014

// Reset cause flag bit positions
`define BIT_COLD_WARM 0
`define BIT_HW_CAUSE 1
`define BIT_SOFT_CAUSE 2
`define BIT_WDT_CAUSE 3
`define BIT_LVL1_CAUSE 4
`define BIT_LVL2_CAUSE 5
`define BIT_OSC_CAUSE 6

// Processor mode register 0 fields
`define BIT_PROC_MODE_LO 0
`define BIT_PROC_MODE_HI 1
`define BIT_SOFT_REQ 3
// Processor mode register 1 field
`define BIT_WDT_ACTION 2
// Oscillator control register 2 fields
`define BIT_CPU_DIV8_SEL 0
`define BIT_OSC_ACTION 7
// Supply monitor control fields
`define BIT_LVL1_SELECT 0
`define BIT_LVL2_SELECT 1

// Reset values
`define RST_PROC_MODE 2'h0
`define RST_WDT_ACTION 1'h0
`define RST_OSC_ACTION 1'h0
`define RST_CPU_DIV8_SEL 1'h1
`define RST_LVL_SELECT 2'h0

// Timing, in low-speed oscillator cycles unless stated
`define CLK_PERIOD_NS 8
`define LVL0_RELEASE_CYCLES 10'h020
`define CPU_DIV 8
`define LVL_EXTRA_CPU_CYCLES 60
`define TPS_NS 160
`define TPS_CYCLES ((`TPS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LVL_WAIT_CYCLES (`TPS_CYCLES + `LVL_EXTRA_CPU_CYCLES * `CPU_DIV)
`define SHORT_RESET_CYCLES 10'h008

`endif

// file: hdl/reset_source_sequencer.v
// Function
// - Power-up: release after 32 oscillator cycles
// - Every reset selects oscillator divided by eight
// - Cold/warm flag cleared by power-up and level-0 resets
// - Cold/warm flag set only by software
// - Level-0 drop resets; release after 32
// - Level-1 reset waits tps plus 60
// - Level-1 reset sets its cause flag
// - Level-2 reset waits tps plus 60
// - Level-2 reset sets its cause flag
// - Warm resets keep processor mode bits
// - Oscillator stop with action 0 halts
// - Oscillator-stop reset sets its cause flag
// - Halt left by hardware or level-0
// - Watchdog underflow with action 1 resets
// - Watchdog reset sets its cause flag
// - Software reset bit restarts the device
// - Software reset sets its cause flag
// - No reset clears internal RAM
// - Level-0 threshold follows select option bit
// - Hardware reset sets its flag and clears the soft, watchdog, level-1 and level-2 flags
// - Oscillator-stop flag cleared by writing 0
// - Power-up and level-0 resets clear every cause flag
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "reset_source_sequencer_regs.vh"

module reset_source_sequencer (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_reset_pin_n,
  input wire i_lvl0_below,
  input wire i_lvl1_below,
  input wire i_lvl2_below,
  input wire i_osc_stop,
  input wire i_wdt_underflow,
  input wire i_lvl0_threshold_select,
  input wire i_lvl0_start_option,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  output reg o_sys_reset,
  output reg o_cpu_run,
  output reg o_halt,
  output reg o_cpu_clk,
  output reg o_cpu_div8_select,
  output reg [1:0] o_proc_mode,
  output reg o_lvl0_threshold_select,
  output reg o_lvl0_monitor_enable
);

  localparam ST_POR = 3'h0;
  localparam ST_HOLD = 3'h1;
  localparam ST_CNT = 3'h2;
  localparam ST_RUN = 3'h3;
  localparam ST_HALT = 3'h4;

  localparam integer LVL_WAIT = `LVL_WAIT_CYCLES;

  // One lane per asynchronous source; the pin lane idles high so reset fakes no pin reset
  wire [7:0] async_in;
  reg [7:0] sync1_ff;
  reg [7:0] sync2_ff;
  reg [7:0] sync3_ff;
  assign async_in = {i_lvl0_start_option, i_lvl0_threshold_select, i_wdt_underflow,
                     i_osc_stop, i_lvl2_below, i_lvl1_below, i_lvl0_below, i_reset_pin_n};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : gen_sync
      always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          sync1_ff[g] <= (g == 0);
          sync2_ff[g] <= (g == 0);
          sync3_ff[g] <= (g == 0);
        end else begin
          sync1_ff[g] <= async_in[g];
          sync2_ff[g] <= sync1_ff[g];
          sync3_ff[g] <= sync2_ff[g];
        end
      end
    end
  endgenerate

  wire pin_low = ~sync2_ff[0];
  wire lvl0_below = sync2_ff[1];
  wire lvl1_fall = sync2_ff[2] & ~sync3_ff[2];
  wire lvl2_fall = sync2_ff[3] & ~sync3_ff[3];
  wire osc_stopped = sync2_ff[4];
  wire wdt_event = sync2_ff[5] & ~sync3_ff[5];
  wire opt_threshold = sync2_ff[6];
  wire opt_start = sync2_ff[7];

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [9:0] cnt_ff;
  reg [9:0] nxt_cnt;
  reg [6:0] flags_ff;
  reg [6:0] nxt_flags;
  reg [1:0] proc_mode_ff;
  reg [1:0] nxt_proc_mode;
  reg soft_req_ff;
  reg nxt_soft_req;
  reg wdt_action_ff;
  reg nxt_wdt_action;
  reg osc_action_ff;
  reg nxt_osc_action;
  reg div8_sel_ff;
  reg nxt_div8_sel;
  reg [1:0] lvl_sel_ff;
  reg [1:0] nxt_lvl_sel;
  reg lvl0_en_ff;
  reg threshold_ff;
  reg [2:0] div_ff;

  wire running = (state_ff == ST_RUN);
  wire lvl0_trig = lvl0_en_ff & lvl0_below;
  wire osc_trig = running & osc_stopped & ~osc_action_ff;
  wire wdt_trig = running & wdt_event & wdt_action_ff;
  wire lvl1_trig = running & lvl1_fall & lvl_sel_ff[0];
  wire lvl2_trig = running & lvl2_fall & lvl_sel_ff[1];
  wire soft_trig = running & soft_req_ff;
  wire warm_trig = osc_trig | wdt_trig | lvl1_trig | lvl2_trig | soft_trig;
  wire cold_trig = lvl0_trig | pin_low;

  wire apb_setup = i_psel & ~i_penable;
  wire apb_wr = i_psel & i_penable & o_pready & i_pwrite;
  wire [7:0] wbyte = i_pwdata[7:0];

  // Sequencer: a cold source wins in every state except ST_POR
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_POR: begin
        if (~lvl0_below) begin
          nxt_state = ST_CNT;
          nxt_cnt = `LVL0_RELEASE_CYCLES;
        end
      end
      ST_HOLD: begin
        if (~cold_trig) begin
          if (lvl0_below) begin
            nxt_state = ST_HOLD;
          end else begin
            nxt_state = ST_CNT;
            nxt_cnt = `LVL0_RELEASE_CYCLES;
          end
        end
      end
      ST_CNT: begin
        if (cnt_ff <= 10'h001) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_cnt = cnt_ff - 10'h001;
        end
      end
      ST_RUN: begin
        if (osc_trig) begin
          nxt_state = ST_HALT;
        end else if (wdt_trig | soft_trig) begin
          nxt_state = ST_CNT;
          nxt_cnt = `SHORT_RESET_CYCLES;
        end else if (lvl1_trig | lvl2_trig) begin
          nxt_state = ST_CNT;
          nxt_cnt = LVL_WAIT[9:0];
        end
      end
      ST_HALT: begin
        nxt_state = ST_HALT;
      end
      default: begin
        nxt_state = ST_POR;
      end
    endcase
    if (cold_trig && state_ff != ST_POR) begin
      nxt_state = ST_HOLD;
    end
  end

  // Cause flags and the registers that the reset sources act on
  always @* begin
    nxt_flags = flags_ff;
    nxt_proc_mode = proc_mode_ff;
    nxt_soft_req = soft_req_ff;
    nxt_wdt_action = wdt_action_ff;
    nxt_osc_action = osc_action_ff;
    nxt_div8_sel = div8_sel_ff;
    nxt_lvl_sel = lvl_sel_ff;
    if (apb_wr) begin
      case (i_paddr)
        `ADDR_CAUSE_FLAGS: begin
          if (wbyte[`BIT_COLD_WARM]) begin
            nxt_flags[`BIT_COLD_WARM] = 1'b1;
          end
          if (~wbyte[`BIT_OSC_CAUSE]) begin
            nxt_flags[`BIT_OSC_CAUSE] = 1'b0;
          end
        end
        `ADDR_PROC_MODE0: begin
          nxt_proc_mode = wbyte[`BIT_PROC_MODE_HI:`BIT_PROC_MODE_LO];
          nxt_soft_req = wbyte[`BIT_SOFT_REQ];
        end
        `ADDR_PROC_MODE1: begin
          nxt_wdt_action = wbyte[`BIT_WDT_ACTION];
        end
        `ADDR_OSC_CTRL2: begin
          nxt_div8_sel = wbyte[`BIT_CPU_DIV8_SEL];
          nxt_osc_action = wbyte[`BIT_OSC_ACTION];
        end
        `ADDR_LVL_CTRL: begin
          nxt_lvl_sel = wbyte[`BIT_LVL2_SELECT:`BIT_LVL1_SELECT];
        end
        default: begin
          nxt_flags = flags_ff;
        end
      endcase
    end
    // A reset event overrides a same-cycle write to each register that it reloads
    if (cold_trig | warm_trig) begin
      nxt_soft_req = 1'b0;
      nxt_wdt_action = `RST_WDT_ACTION;
      nxt_osc_action = `RST_OSC_ACTION;
      nxt_div8_sel = `RST_CPU_DIV8_SEL;
    end
    if (lvl0_trig) begin
      nxt_flags = 7'h00;
      nxt_proc_mode = `RST_PROC_MODE;
      nxt_lvl_sel = `RST_LVL_SELECT;
    end else if (pin_low) begin
      nxt_flags[`BIT_HW_CAUSE] = 1'b1;
      nxt_flags[`BIT_SOFT_CAUSE] = 1'b0;
      nxt_flags[`BIT_WDT_CAUSE] = 1'b0;
      nxt_flags[`BIT_LVL1_CAUSE] = 1'b0;
      nxt_flags[`BIT_LVL2_CAUSE] = 1'b0;
      nxt_proc_mode = `RST_PROC_MODE;
      nxt_lvl_sel = `RST_LVL_SELECT;
    end else if (warm_trig) begin
      nxt_flags[`BIT_HW_CAUSE] = 1'b0;
      nxt_flags[`BIT_OSC_CAUSE] = osc_trig;
      nxt_flags[`BIT_WDT_CAUSE] = ~osc_trig & wdt_trig;
      nxt_flags[`BIT_SOFT_CAUSE] = ~osc_trig & ~wdt_trig & soft_trig;
      nxt_flags[`BIT_LVL1_CAUSE] = ~osc_trig & ~wdt_trig & ~soft_trig & lvl1_trig;
      nxt_flags[`BIT_LVL2_CAUSE] = ~osc_trig & ~wdt_trig & ~soft_trig
                                   & ~lvl1_trig & lvl2_trig;
    end
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_POR;
      cnt_ff <= 10'h000;
      flags_ff <= 7'h00;
      proc_mode_ff <= `RST_PROC_MODE;
      soft_req_ff <= 1'b0;
      wdt_action_ff <= `RST_WDT_ACTION;
      osc_action_ff <= `RST_OSC_ACTION;
      div8_sel_ff <= `RST_CPU_DIV8_SEL;
      lvl_sel_ff <= `RST_LVL_SELECT;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      flags_ff <= nxt_flags;
      proc_mode_ff <= nxt_proc_mode;
      soft_req_ff <= nxt_soft_req;
      wdt_action_ff <= nxt_wdt_action;
      osc_action_ff <= nxt_osc_action;
      div8_sel_ff <= nxt_div8_sel;
      lvl_sel_ff <= nxt_lvl_sel;
    end
  end

  // Option bits are sampled while a cold or pin reset holds the chip,
  // so a change at run time does not move the threshold under the detector
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      lvl0_en_ff <= 1'b0;
      threshold_ff <= 1'b0;
    end else if (state_ff == ST_POR || state_ff == ST_HOLD) begin
      lvl0_en_ff <= ~opt_start;
      threshold_ff <= opt_threshold;
    end
  end

  // CPU clock: low-speed oscillator divided by eight
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // Outputs; RAM has no reset path here at all
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sys_reset <= 1'b1;
      o_cpu_run <= 1'b0;
      o_halt <= 1'b0;
      o_cpu_clk <= 1'b0;
      o_cpu_div8_select <= `RST_CPU_DIV8_SEL;
      o_proc_mode <= `RST_PROC_MODE;
      o_lvl0_threshold_select <= 1'b0;
      o_lvl0_monitor_enable <= 1'b0;
    end else begin
      o_sys_reset <= (nxt_state != ST_RUN);
      o_cpu_run <= (nxt_state == ST_RUN);
      o_halt <= (nxt_state == ST_HALT);
      o_cpu_clk <= div_ff[2];
      o_cpu_div8_select <= nxt_div8_sel;
      o_proc_mode <= nxt_proc_mode;
      o_lvl0_threshold_select <= threshold_ff;
      o_lvl0_monitor_enable <= lvl0_en_ff;
    end
  end

  // APB slave: data prepared in setup, one-cycle access phase
  reg [31:0] rd_mux;
  reg rd_err;
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (i_paddr)
      `ADDR_CAUSE_FLAGS: begin
        rd_mux[6:0] = flags_ff;
      end
      `ADDR_PROC_MODE0: begin
        rd_mux[`BIT_PROC_MODE_HI:`BIT_PROC_MODE_LO] = proc_mode_ff;
        rd_mux[`BIT_SOFT_REQ] = soft_req_ff;
      end
      `ADDR_PROC_MODE1: begin
        rd_mux[`BIT_WDT_ACTION] = wdt_action_ff;
      end
      `ADDR_OSC_CTRL2: begin
        rd_mux[`BIT_CPU_DIV8_SEL] = div8_sel_ff;
        rd_mux[`BIT_OSC_ACTION] = osc_action_ff;
      end
      `ADDR_LVL_CTRL: begin
        rd_mux[`BIT_LVL2_SELECT:`BIT_LVL1_SELECT] = lvl_sel_ff;
      end
      `ADDR_STATUS: begin
        rd_mux[2:0] = state_ff;
        rd_mux[3] = lvl0_en_ff;
        rd_mux[4] = threshold_ff;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= apb_setup;
      o_pslverr <= apb_setup & rd_err;
      if (apb_setup && !i_pwrite) begin
        o_prdata <= rd_mux;
      end else if (!i_psel) begin
        o_prdata <= 32'h00000000;
      end
    end
  end

endmodule

// file: testbench/reset_seq_props.sv
`timescale 1ns/100ps
module reset_seq_props (
  input wire i_core_clk,
  input wire i_rst,
  input wire i_reset_pin_n,
  input wire i_lvl0_below,
  input wire i_lvl0_threshold_select,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire o_pready,
  input wire o_pslverr,
  input wire o_sys_reset,
  input wire o_cpu_run,
  input wire o_halt,
  input wire o_cpu_clk,
  input wire o_cpu_div8_select,
  input wire [1:0] o_proc_mode,
  input wire o_lvl0_threshold_select,
  input wire o_lvl0_monitor_enable
);
  reg cold_ff;
  reg [5:0] quiet_ff;
  // Marks a cold reset in flight; cleared once the CPU runs again
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cold_ff <= 1'b1;
      quiet_ff <= 6'h00;
    end else begin
      if (!i_reset_pin_n || (i_lvl0_below && o_lvl0_monitor_enable))
        cold_ff <= 1'b1;
      else if (!o_sys_reset)
        cold_ff <= 1'b0;
      if (o_sys_reset && i_reset_pin_n && !i_lvl0_below)
        quiet_ff <= quiet_ff + {5'h00, quiet_ff != 6'h3F};
      else
        quiet_ff <= 6'h00;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  sequence clk_hi4; o_cpu_clk [*4]; endsequence
  sequence clk_lo4; !o_cpu_clk [*4]; endsequence
  run_inverse_a: assert property (o_cpu_run == !o_sys_reset)
    else $error("run and reset disagree");
  div8_reset_a: assert property (o_sys_reset |-> o_cpu_div8_select)
    else $error("divide by eight not selected in reset");
  cpu_clk_div_a: assert property (disable iff (i_rst || o_halt || o_sys_reset)
    $rose(o_cpu_clk) |-> clk_hi4 ##1 clk_lo4 ##1 o_cpu_clk) else $error("cpu clock not div8");
  cold_release_a: assert property ($fell(o_sys_reset) && cold_ff |->
    quiet_ff >= 6'h20 && quiet_ff <= 6'h28) else $error("cold release count wrong");
  halt_keep_a: assert property ((o_halt && i_reset_pin_n && !i_lvl0_below) [*5]
    |=> o_halt) else $error("halt left without cause");
  halt_stop_a: assert property (o_halt |-> !o_cpu_run)
    else $error("cpu runs while halted");
  mode_keep_a: assert property (!cold_ff && !(i_psel && i_penable && i_pwrite)
    |=> $stable(o_proc_mode)) else $error("mode bits changed");
  thr_follow_a: assert property (o_cpu_run |->
    o_lvl0_threshold_select == i_lvl0_threshold_select) else $error("threshold select off");
  pready_next_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  slverr_map_a: assert property (o_pready && i_paddr[1:0] == 2'h0 |->
    o_pslverr == (i_paddr > 12'h014)) else $error("slave error wrong");
endmodule

bind reset_source_sequencer reset_seq_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_reset_pin_n(i_reset_pin_n), .i_lvl0_below(i_lvl0_below), .i_psel(i_psel),
  .i_lvl0_threshold_select(i_lvl0_threshold_select), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_sys_reset(o_sys_reset), .o_cpu_run(o_cpu_run), .o_halt(o_halt), .o_cpu_clk(o_cpu_clk),
  .o_cpu_div8_select(o_cpu_div8_select), .o_proc_mode(o_proc_mode),
  .o_lvl0_threshold_select(o_lvl0_threshold_select),
  .o_lvl0_monitor_enable(o_lvl0_monitor_enable));

// file: testbench/supply_model.sv
`timescale 1ns/100ps
module supply_model #(
  parameter logic [12:0] LVL1_MV = 13'hCE4,
  parameter logic [12:0] LVL2_MV = 13'hC1C
) (
  input wire logic [12:0] i_supply_mv,
  input wire logic i_thr_sel,
  output logic o_lvl0_below,
  output logic o_lvl1_below,
  output logic o_lvl2_below
);
  // Millivolts: 1.90 V when the option bit is 1, else 2.85 V
  assign o_lvl0_below = i_supply_mv <= (i_thr_sel ? 13'h76C : 13'hB22);
  assign o_lvl1_below = i_supply_mv <= LVL1_MV;
  assign o_lvl2_below = i_supply_mv <= LVL2_MV;
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/100ps
`include "reset_source_sequencer_regs.vh"
module tb_top;
  logic clk = 1'b0, rst = 1'b1, pin_n = 1'b1, osc = 1'b0, wdt = 1'b0, thr = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0, prd, q;
  logic [12:0] mv = 13'hE10;
  logic rdy, err, e, sres, run, halt, cclk, div8, tsel, men, b0, b1, b2;
  logic [1:0] pm;
  integer n_mismatch = 0, n_tests = 0, n;
  always #4 clk = ~clk;
  supply_model u_supply (.i_supply_mv(mv), .i_thr_sel(tsel), .o_lvl0_below(b0),
    .o_lvl1_below(b1), .o_lvl2_below(b2));
  reset_source_sequencer DUT (.i_core_clk(clk), .i_rst(rst), .i_reset_pin_n(pin_n),
    .i_lvl0_below(b0), .i_lvl1_below(b1), .i_lvl2_below(b2), .i_osc_stop(osc),
    .i_wdt_underflow(wdt), .i_lvl0_threshold_select(thr), .i_lvl0_start_option(1'b0),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd),
    .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .o_sys_reset(sres), .o_cpu_run(run),
    .o_halt(halt), .o_cpu_clk(cclk), .o_cpu_div8_select(div8), .o_proc_mode(pm),
    .o_lvl0_threshold_select(tsel), .o_lvl0_monitor_enable(men));
  task results;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_tests++;
      if (got !== exp) begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (rdy !== 1'b1);
      q = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
      chk("ready", 1, k < 20);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, exp, q);
    end
  endtask
  // Length of the reset phase, bounded in case release never comes
  task hold_len;
    begin
      n = 0;
      while (sres !== 1'b1 && n < 50) begin
        @(posedge clk);
        n++;
      end
      n = 0;
      while (run !== 1'b1 && n < 1000) begin
        @(posedge clk);
        n++;
      end
    end
  endtask
  task t_por;
    begin
      hold_len;
      chk("por_wait", 1, n >= 32 && n <= 40);
      rd(`ADDR_CAUSE_FLAGS, 32'h0, "flags_por");
      rd(`ADDR_OSC_CTRL2, 32'h1, "div8_por");
      chk("mon_en", 1, men);
    end
  endtask
  task t_cw;
    begin
      apb(1'b1, `ADDR_CAUSE_FLAGS, 32'h41);
      rd(`ADDR_CAUSE_FLAGS, 32'h1, "cw_set");
      apb(1'b1, `ADDR_PROC_MODE0, 32'h2);
    end
  endtask
  task t_warm(input integer kind);
    integer w;
    begin
      apb(1'b1, `ADDR_OSC_CTRL2, 32'h0);
      rd(`ADDR_OSC_CTRL2, 32'h0, "div8_off");
      w = `SHORT_RESET_CYCLES;
      case (kind)
        0: apb(1'b1, `ADDR_PROC_MODE0, 32'hA);
        1: begin
          apb(1'b1, `ADDR_PROC_MODE1, 32'h4);
          wdt <= 1'b1;
        end
        default: begin
          apb(1'b1, `ADDR_LVL_CTRL, kind - 1);
          mv <= 13'hBB8;
          w = `LVL_WAIT_CYCLES;
        end
      endcase
      hold_len;
      wdt <= 1'b0;
      mv <= 13'hE10;
      chk("warm_wait", 1, n >= w && n <= w + 4);
      chk("div8", 1, div8);
      rd(`ADDR_CAUSE_FLAGS, 1 | (4 << kind), "warm_flags");
      rd(`ADDR_PROC_MODE0, 32'h2, "mode_kept");
      chk("pm_kept", 32'h2, pm);
    end
  endtask
  task t_osc;
    begin
      osc <= 1'b1;
      repeat (100) @(posedge clk);
      osc <= 1'b0;
      repeat (50) @(posedge clk);
      chk("halt", 1, halt);
      chk("halt_run", 0, run);
      pin_n <= 1'b0;
      repeat (10) @(posedge clk);
      pin_n <= 1'b1;
      hold_len;
      rd(`ADDR_CAUSE_FLAGS, 32'h43, "hw_flags");
      apb(1'b1, `ADDR_CAUSE_FLAGS, 32'h0);
      rd(`ADDR_CAUSE_FLAGS, 32'h3, "osc_clear");
    end
  endtask
  task t_lvl0;
    begin
      apb(1'b1, `ADDR_LVL_CTRL, 32'h0);
      mv <= 13'h640;
      repeat (20) @(posedge clk);
      thr <= 1'b1;
      repeat (20) @(posedge clk);
      mv <= 13'hE10;
      hold_len;
      chk("lvl0_wait", 1, n >= 32 && n <= 40);
      rd(`ADDR_CAUSE_FLAGS, 32'h0, "flags_cold");
      chk("thr_sel", 1, tsel);
      mv <= 13'h7D0;
      repeat (50) @(posedge clk);
      chk("low_thr_run", 1, run);
      mv <= 13'hE10;
      pin_n <= 1'b0;
      repeat (5) @(posedge clk);
      thr <= 1'b0;
      repeat (5) @(posedge clk);
      pin_n <= 1'b1;
      hold_len;
      chk("thr_back", 0, tsel);
    end
  endtask
  task t_bad;
    begin
      rd(12'h020, 32'h0, "bad_rd");
      chk("bad_err", 1, e);
      rd(`ADDR_STATUS, 32'hB, "status");
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_por;
    t_cw;
    for (int k = 0; k < 4; k++)
      t_warm(k);
    t_osc;
    t_lvl0;
    t_bad;
    results;
  end
  initial begin
    #200000;
    n_mismatch++;
    results;
  end
endmodule
